// *** pkg/rld_consts.vh ***
// Constants of the RPE-LTP excitation and synthesis datapath.
// Assumes inclusion by bare name from the design file; definitions only.
// What this block does
// (R1) Block maximum is the largest pulse magnitude of 13, starting from zero.
// (R2) Exponent is zero, or coded max >> 3 minus 1 above 15; mantissa follows.
// (R3) Small mantissas are normalised into 8..15 by shifting in ones.
// (R4) Pulse codes come from exponent shift and inverse-mantissa multiply, no division.
// (R5) Each coded pulse is offset by four to make it non-negative.
// (R6) Exponent and mantissa are kept for the inverse quantiser.
// (R7) Inverse quantiser uses direct-mantissa constant and restores pulse sign.
// (R8) Excitation is 40 zeros with pulse i at grid plus three times i.
// (R9) Encoder history shifts by 40; newest 40 get saturated excitation plus estimate.
// (R10) Excitation and long-term synthesis per sub-segment; filtering per frame.
// (R11) Decoder excitation reuses exponent/mantissa, inverse quantiser and grid placement.
// (R12) Lag outside 40..120 is replaced by the previous lag, initially 40.
// (R13) Synthesis output is excitation plus rounded gain times lagged history, saturated.
// (R14) Gain codes 0..3 map to 3277, 11469, 21299 and 32767.
// (R15) Decoder history shifts by 40 over 120 samples, zero after reset.
// (R16) Area codes decoded once per frame with reciprocal scales, interpolated, converted.
// (R17) Code offsets and limits are -32/31, -16/15, -8/7, -4/3 per pair.
// (R18) Sub-segment n outputs land at 40n onward in a 160-sample frame buffer.
// (R19) Nine-element lattice state persists between frames, zero after reset.
// (R20) Lattice runs stage 8 down to 1, subtracting then updating the state.
// (R21) De-emphasis adds rounded previous output times 28180; state persists.
// (R22) Every de-emphasised sample is doubled with saturation.
// (R23) Three low output bits are cleared.
// (R24) Companding takes output >> 3; law select 1 is A-law, 0 mu-law.
`ifndef RLD_CONSTS_VH
`define RLD_CONSTS_VH
`define RLD_SEG_LAST   8'h27
`define RLD_FRM_LAST   8'h9f
`define RLD_PULSE_LAST 4'hc
`define RLD_HIST_LEN   8'h78
`define RLD_LAG_MIN    7'h28
`define RLD_LAG_MAX    7'h78
`define RLD_LAG_INIT   7'h28
`define RLD_GRID_STEP  6'h03
`define RLD_XMAX_SMALL 6'h0f
`define RLD_EXP_REF    4'h6
`define RLD_PULSE_OFS  16'sh0004
`define RLD_QSHIFT     12
`define RLD_ROUND      32'sh00004000
`define RLD_GLVL0      16'sh0ccd
`define RLD_GLVL1      16'sh2ccd
`define RLD_GLVL2      16'sh5333
`define RLD_GLVL3      16'sh7fff
`define RLD_INVM0      16'sh71c8
`define RLD_INVM1      16'sh6667
`define RLD_INVM2      16'sh5d18
`define RLD_INVM3      16'sh5556
`define RLD_INVM4      16'sh4ec5
`define RLD_INVM5      16'sh4925
`define RLD_INVM6      16'sh4444
`define RLD_INVM7      16'sh4000
`define RLD_DIRM_BASE  16'sh47ff
`define RLD_DIRM_STEP  16'sh0800
`define RLD_RCP_LO     16'sh3333
`define RLD_RCP5       16'sh4b17
`define RLD_RCP6       16'sh4444
`define RLD_RCP7       16'sh7ade
`define RLD_RCP8       16'sh740c
`define RLD_CMIN12     16'shffe0
`define RLD_CMIN34     16'shfff0
`define RLD_CMIN56     16'shfff8
`define RLD_CMIN78     16'shfffc
`define RLD_CMAX12     16'sh001f
`define RLD_CMAX34     16'sh000f
`define RLD_CMAX56     16'sh0007
`define RLD_CMAX78     16'sh0003
`define RLD_B3         16'sh0800
`define RLD_B4         16'shf600
`define RLD_B5         16'sh005e
`define RLD_B6         16'shf900
`define RLD_B7         16'shfeab
`define RLD_B8         16'shfb88
`define RLD_INT_A      8'h0c
`define RLD_INT_B      8'h1a
`define RLD_RP_T1      16'sh2b33
`define RLD_RP_T2      16'sh4e66
`define RLD_RP_OFS     16'sh6600
`define RLD_DEEMPH     16'sh6e14
`define RLD_TRUNC_MASK 16'hfff8
`define RLD_ALAW_XOR   8'h55
`define RLD_MU_BIAS    14'h0021
`define RLD_MU_CLIP    14'h1fff
`endif

// *** logic/rld_datapath.v ***
// RPE-LTP excitation coding and speech synthesis datapath, plus output FIFO.
// Assumes a 20 MHz clock, synchronous inputs and a consumer draining out_data.
`timescale 1ns/1ns
`default_nettype none
`include "rld_consts.vh"

module rld_fifo #(
	parameter W     = 16,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	// DEPTH must equal 2**AW
	localparam [AW:0] FULL = {1'b1, {AW{1'b0}}};
	reg  [W-1:0] mem [0:DEPTH-1];
	reg  [AW:0]  wp_q;
	reg  [AW:0]  rp_q;
	wire [AW:0]  used = wp_q - rp_q;

	assign in_ready  = used != FULL;
	assign out_valid = used != {(AW+1){1'b0}};
	assign out_data  = mem[rp_q[AW-1:0]];

	always @(posedge clock) begin
		if (in_valid && in_ready)
			mem[wp_q[AW-1:0]] <= in_data;
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && in_ready)
				wp_q <= wp_q + 1'b1;
			if (out_valid && out_ready)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule

module rld_datapath #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire         enc_valid,
	output wire         enc_ready,
	input  wire [207:0] enc_pulses,
	input  wire [1:0]   enc_grid,
	input  wire [5:0]   enc_coded_max,
	output wire [5:0]   est_index,
	input  wire [15:0]  est_sample,
	output wire         enc_done,
	output wire [15:0]  enc_block_max,
	output wire [38:0]  enc_coded_pulses,
	input  wire [6:0]   hist_age,
	output wire [15:0]  hist_data,
	input  wire         sub_valid,
	output wire         sub_ready,
	input  wire [1:0]   sub_grid,
	input  wire [5:0]   sub_coded_max,
	input  wire [38:0]  sub_pulses,
	input  wire [6:0]   sub_lag,
	input  wire [1:0]   sub_gain,
	input  wire [47:0]  lar_codes,
	output wire [1:0]   sub_index,
	input  wire         compand_en,
	input  wire         law_sel,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [15:0]  out_data
);
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_ENQ  = 6'h02;
	localparam [5:0] S_ENX  = 6'h04;
	localparam [5:0] S_LTP  = 6'h08;
	localparam [5:0] S_STS  = 6'h10;
	localparam [5:0] S_OUT  = 6'h20;

	function signed [15:0] sat16;
		input signed [17:0] x;
		begin
			if (x > 18'sh07fff)
				sat16 = 16'sh7fff;
			else if (x < 18'sh38000)
				sat16 = 16'sh8000;
			else
				sat16 = x[15:0];
		end
	endfunction

	function signed [15:0] sadd;
		input signed [15:0] a;
		input signed [15:0] b;
		begin
			sadd = sat16({a[15], a[15], a} + {b[15], b[15], b});
		end
	endfunction

	function signed [15:0] ssub;
		input signed [15:0] a;
		input signed [15:0] b;
		begin
			ssub = sat16({a[15], a[15], a} - {b[15], b[15], b});
		end
	endfunction

	// Fractional multiply; only -1 times -1 overflows
	function signed [15:0] mulq;
		input signed [15:0] a;
		input signed [15:0] b;
		input               rnd;
		reg signed [31:0] p;
		begin
			p = a * b + (rnd ? `RLD_ROUND : 32'sh0);
			if (a == 16'sh8000 && b == 16'sh8000)
				mulq = 16'sh7fff;
			else
				mulq = p[30:15];
		end
	endfunction

	function signed [15:0] sabs;
		input signed [15:0] x;
		begin
			sabs = x[15] ? ssub(16'sh0, x) : x;
		end
	endfunction

	function signed [15:0] inv_mant;
		input [2:0] m;
		begin
			case (m)
			3'h0: inv_mant = `RLD_INVM0;
			3'h1: inv_mant = `RLD_INVM1;
			3'h2: inv_mant = `RLD_INVM2;
			3'h3: inv_mant = `RLD_INVM3;
			3'h4: inv_mant = `RLD_INVM4;
			3'h5: inv_mant = `RLD_INVM5;
			3'h6: inv_mant = `RLD_INVM6;
			default: inv_mant = `RLD_INVM7;
			endcase
		end
	endfunction

	// Returns {exponent[3:0] signed, mantissa[2:0]}
	function [6:0] expm;
		input [5:0] xc;
		reg [3:0] e;
		reg [4:0] mt;
		integer j;
		begin
			e = (xc > `RLD_XMAX_SMALL) ? ({1'b0, xc[5:3]} - 4'h1) : 4'h0; // R2
			mt = {1'b0, xc[3:0]} - {e[1:0], 3'h0};
			if (xc > `RLD_XMAX_SMALL)
				// Modulo 32 is exact: the result lies in 8..15
				mt = xc[4:0] - {e[1:0], 3'h0};
			if (mt == 5'h00) begin
				e = 4'hc;
				mt = 5'h0f;
			end else begin
				for (j = 0; j < 3; j = j + 1) begin
					if (mt <= 5'h07) begin // R3
						mt = {mt[3:0], 1'b1};
						e = e - 4'h1;
					end
				end
			end
			expm = {e, mt[2:0]};
		end
	endfunction

	function [2:0] quant;
		input signed [15:0] x;
		input        [3:0]  e;
		input        [2:0]  m;
		reg signed [15:0] t;
		reg        [3:0]  sh;
		begin
			sh = `RLD_EXP_REF - e;
			t = x << sh; // R4
			t = mulq(t, inv_mant(m), 1'b0); // R4
			t = (t >>> `RLD_QSHIFT) + `RLD_PULSE_OFS; // R5
			quant = t[2:0];
		end
	endfunction

	function signed [15:0] invq;
		input [2:0] c;
		input [3:0] e;
		input [2:0] m;
		reg signed [15:0] t;
		reg signed [15:0] f;
		reg        [3:0]  sh;
		begin
			sh = `RLD_EXP_REF - e;
			f = `RLD_DIRM_BASE + `RLD_DIRM_STEP * $signed({13'h0, m}); // R7
			t = ($signed({12'h0, c, 1'b0}) - 16'sh0007) <<< 12; // R7
			t = mulq(f, t, 1'b1);
			if (sh != 4'h0)
				t = sadd(t, 16'sh0001 << (sh - 4'h1));
			invq = t >>> sh;
		end
	endfunction

	function signed [15:0] lar_dec;
		input integer    i;
		input [5:0] code;
		reg signed [15:0] cmin;
		reg signed [15:0] cmax;
		reg signed [15:0] rcp;
		reg signed [15:0] b;
		reg signed [15:0] t;
		begin
			case ((i - 1) / 2)
			0: begin cmin = `RLD_CMIN12; cmax = `RLD_CMAX12; end // R17
			1: begin cmin = `RLD_CMIN34; cmax = `RLD_CMAX34; end // R17
			2: begin cmin = `RLD_CMIN56; cmax = `RLD_CMAX56; end // R17
			default: begin cmin = `RLD_CMIN78; cmax = `RLD_CMAX78; end // R17
			endcase
			case (i)
			3: b = `RLD_B3;
			4: b = `RLD_B4;
			5: b = `RLD_B5;
			6: b = `RLD_B6;
			7: b = `RLD_B7;
			8: b = `RLD_B8;
			default: b = 16'sh0;
			endcase
			case (i)
			5: rcp = `RLD_RCP5;
			6: rcp = `RLD_RCP6;
			7: rcp = `RLD_RCP7;
			8: rcp = `RLD_RCP8;
			default: rcp = `RLD_RCP_LO; // R16
			endcase
			t = $signed({10'h0, code}) + cmin;
			if (t > cmax)
				t = cmax;
			t = ssub(t <<< 10, b <<< 1);
			t = mulq(rcp, t, 1'b1); // R16
			lar_dec = sadd(t, t);
		end
	endfunction

	function signed [15:0] interp;
		input signed [15:0] p;
		input signed [15:0] c;
		input        [7:0]  k;
		begin
			if (k <= `RLD_INT_A)
				interp = sadd(sadd(p >>> 2, c >>> 2), p >>> 1);
			else if (k <= `RLD_INT_B)
				interp = sadd(p >>> 1, c >>> 1);
			else if (k <= `RLD_SEG_LAST)
				interp = sadd(sadd(p >>> 2, c >>> 2), c >>> 1);
			else
				interp = c;
		end
	endfunction

	function signed [15:0] rp_of;
		input signed [15:0] l;
		reg signed [15:0] t;
		begin
			t = sabs(l);
			if (t < `RLD_RP_T1)
				t = t <<< 1;
			else if (t < `RLD_RP_T2)
				t = sadd(t, `RLD_RP_T1);
			else
				t = sadd(t >>> 2, `RLD_RP_OFS);
			rp_of = l[15] ? ssub(16'sh0, t) : t;
		end
	endfunction

	// Segment/mantissa companding of a 13-bit sample
	function [7:0] compress;
		input [12:0] x;
		input        law;
		reg [12:0] m13;
		reg [13:0] mag;
		reg [13:0] sh;
		reg [2:0]  seg;
		integer j;
		begin
			m13 = x[12] ? (13'h0 - x) : x;
			if (law)
				mag = x[12] ? {1'b0, ~x} : {1'b0, x};
			else
				mag = {m13, 1'b0} + `RLD_MU_BIAS;
			if (!law && mag > `RLD_MU_CLIP)
				mag = `RLD_MU_CLIP;
			seg = 3'h0;
			for (j = 1; j < 8; j = j + 1) begin
				if (mag >= ((law ? 14'h0010 : 14'h0020) << j))
					seg = j[2:0];
			end
			if (law) begin
				sh = (seg == 3'h0) ? (mag >> 1) : (mag >> seg);
				compress = {~x[12], seg, sh[3:0]} ^ `RLD_ALAW_XOR;
			end else begin
				// Four-bit shift count so segment 7 shifts by 8
				sh = mag >> ({1'b0, seg} + 4'h1);
				compress = {1'b0, seg, sh[3:0]} ^ (x[12] ? 8'h7f : 8'hff);
			end
		end
	endfunction

	reg        [5:0]  st_q;
	reg        [7:0]  k_q;
	reg        [3:0]  pi_q;
	reg        [5:0]  npos_q;
	reg        [3:0]  stage_q;
	reg        [1:0]  sub_q;
	reg        [3:0]  exp_q;
	reg        [2:0]  mant_q;
	reg        [6:0]  nrp_q;
	reg signed [15:0] brp_q;
	reg        [6:0]  dwp_q;
	reg        [6:0]  ewp_q;
	reg signed [15:0] sri_q;
	reg signed [15:0] msr_q;
	reg signed [15:0] bmax_q;
	reg               done_q;
	reg signed [15:0] hist_q;
	reg signed [15:0] dh [0:119];
	reg signed [15:0] eh [0:119];
	reg signed [15:0] fbuf [0:159];
	reg signed [15:0] v_q [0:8];
	reg signed [15:0] lc_q [1:8];
	reg signed [15:0] lp_q [1:8];
	reg        [2:0]  coded_q [0:12];
	wire signed [15:0] lar_new [1:8];
	integer i;

	genvar g;
	generate
		for (g = 1; g <= 8; g = g + 1) begin : g_lar
			assign lar_new[g] = lar_dec(g, lar_codes[6*(g-1) +: 6]); // R16
		end
		for (g = 0; g < 13; g = g + 1) begin : g_cp
			assign enc_coded_pulses[3*g +: 3] = coded_q[g];
		end
	endgenerate

	wire        [6:0]  lag_use = (sub_lag < `RLD_LAG_MIN || sub_lag > `RLD_LAG_MAX) ? nrp_q : sub_lag; // R12
	wire        [6:0]  xmax_sel = st_q[0] && enc_valid ? {1'b0, enc_coded_max} : {1'b0, sub_coded_max};
	wire        [6:0]  em = expm(xmax_sel[5:0]);
	wire               hit = (k_q[5:0] == npos_q) && (pi_q <= `RLD_PULSE_LAST);
	wire        [3:0]  pidx = hit ? pi_q : 4'h0;
	wire signed [15:0] exc = hit ? invq(coded_q[pidx], exp_q, mant_q) : 16'sh0; // R8 R11
	wire        [7:0]  dsum = {1'b0, dwp_q} + `RLD_HIST_LEN - {1'b0, nrp_q};
	wire        [7:0]  dslot = (dsum >= `RLD_HIST_LEN) ? dsum - `RLD_HIST_LEN : dsum;
	wire        [7:0]  hsum = {1'b0, ewp_q} + `RLD_HIST_LEN - {1'b0, hist_age};
	wire        [7:0]  hslot = (hsum >= `RLD_HIST_LEN) ? hsum - `RLD_HIST_LEN : hsum;
	wire signed [15:0] ltp_out = sadd(exc, mulq(brp_q, dh[dslot[6:0]], 1'b1)); // R13
	wire        [7:0]  fbuf_w = {1'b0, sub_q, 5'h0} + {3'h0, sub_q, 3'h0} + k_q; // R18
	wire signed [15:0] enc_x = enc_pulses[{pi_q, 4'h0} +: 16];
	wire signed [15:0] rp_s = rp_of(interp(lp_q[stage_q], lc_q[stage_q], k_q)); // R16
	wire signed [15:0] vm1 = v_q[stage_q - 4'h1];
	wire signed [15:0] sri_n = ssub(sri_q, mulq(rp_s, vm1, 1'b1)); // R20
	wire signed [15:0] msr_n = sadd(sri_q, mulq(msr_q, `RLD_DEEMPH, 1'b1)); // R21
	wire signed [15:0] up = sadd(msr_n, msr_n); // R22
	wire        [15:0] trunc = up & `RLD_TRUNC_MASK; // R23
	wire        [15:0] out_word = compand_en ? {8'h00, compress(trunc[15:3], law_sel)} : trunc; // R24
	wire               fifo_ready;
	wire signed [15:0] gain_lvl = (sub_gain == 2'h0) ? `RLD_GLVL0 : (sub_gain == 2'h1) ? `RLD_GLVL1 :
	                              (sub_gain == 2'h2) ? `RLD_GLVL2 : `RLD_GLVL3; // R14

	assign enc_ready     = st_q[0];
	assign sub_ready     = st_q[0] && !enc_valid;
	assign est_index     = k_q[5:0];
	assign enc_done      = done_q;
	assign enc_block_max = bmax_q;
	assign hist_data     = hist_q;
	assign sub_index     = sub_q;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			k_q <= 8'h0;
			pi_q <= 4'h0;
			npos_q <= 6'h0;
			stage_q <= 4'h0;
			sub_q <= 2'h0;
			exp_q <= 4'h0;
			mant_q <= 3'h0;
			nrp_q <= `RLD_LAG_INIT; // R12
			brp_q <= 16'sh0;
			dwp_q <= 7'h0;
			ewp_q <= 7'h0;
			sri_q <= 16'sh0;
			msr_q <= 16'sh0; // R21
			bmax_q <= 16'sh0;
			done_q <= 1'b0;
			hist_q <= 16'sh0;
			for (i = 0; i < 120; i = i + 1) begin
				dh[i] <= 16'sh0; // R15
				eh[i] <= 16'sh0; // R9
			end
			for (i = 0; i < 160; i = i + 1)
				fbuf[i] <= 16'sh0;
			for (i = 0; i < 9; i = i + 1)
				v_q[i] <= 16'sh0; // R19
			for (i = 1; i < 9; i = i + 1) begin
				lc_q[i] <= 16'sh0;
				lp_q[i] <= 16'sh0;
			end
			for (i = 0; i < 13; i = i + 1)
				coded_q[i] <= 3'h0;
		end else begin
			done_q <= 1'b0;
			hist_q <= eh[hslot[6:0]];
			case (st_q)
			S_IDLE: begin
				k_q <= 8'h0;
				pi_q <= 4'h0;
				{exp_q, mant_q} <= em; // R6 R11
				if (enc_valid) begin
					npos_q <= {4'h0, enc_grid};
					bmax_q <= 16'sh0; // R1
					st_q <= S_ENQ;
				end else if (sub_valid) begin
					npos_q <= {4'h0, sub_grid};
					for (i = 0; i < 13; i = i + 1)
						coded_q[i] <= sub_pulses[3*i +: 3]; // R11
					nrp_q <= lag_use; // R12
					brp_q <= gain_lvl; // R14
					if (sub_q == 2'h0) begin
						for (i = 1; i < 9; i = i + 1) begin
							lp_q[i] <= lc_q[i]; // R16
							lc_q[i] <= lar_new[i]; // R16
						end
					end
					st_q <= S_LTP; // R10
				end
			end
			S_ENQ: begin
				coded_q[pi_q] <= quant(enc_x, exp_q, mant_q); // R4
				if (sabs(enc_x) > bmax_q)
					bmax_q <= sabs(enc_x); // R1
				pi_q <= (pi_q == `RLD_PULSE_LAST) ? 4'h0 : pi_q + 4'h1;
				if (pi_q == `RLD_PULSE_LAST)
					st_q <= S_ENX;
			end
			S_ENX, S_LTP: begin
				if (hit) begin
					pi_q <= pi_q + 4'h1; // R8
					npos_q <= npos_q + `RLD_GRID_STEP; // R8
				end
				k_q <= k_q + 8'h1;
				if (st_q[2]) begin
					eh[ewp_q] <= sadd(exc, $signed(est_sample)); // R9
					ewp_q <= (ewp_q == 7'h77) ? 7'h0 : ewp_q + 7'h1; // R9
					if (k_q == `RLD_SEG_LAST) begin
						done_q <= 1'b1;
						st_q <= S_IDLE;
					end
				end else begin
					dh[dwp_q] <= ltp_out; // R13 R15
					fbuf[fbuf_w] <= ltp_out; // R18
					dwp_q <= (dwp_q == 7'h77) ? 7'h0 : dwp_q + 7'h1; // R15
					if (k_q == `RLD_SEG_LAST) begin
						sub_q <= sub_q + 2'h1;
						k_q <= 8'h0;
						stage_q <= 4'h8;
						sri_q <= fbuf[0];
						st_q <= (sub_q == 2'h3) ? S_STS : S_IDLE; // R10
					end
				end
			end
			S_STS: begin
				v_q[stage_q] <= sadd(vm1, mulq(rp_s, sri_n, 1'b1)); // R20
				sri_q <= sri_n;
				stage_q <= stage_q - 4'h1;
				if (stage_q == 4'h1) begin
					v_q[0] <= sri_n; // R19
					st_q <= S_OUT;
				end
			end
			S_OUT: begin
				// Stalls here while the FIFO is full
				if (fifo_ready) begin
					msr_q <= msr_n; // R21
					k_q <= k_q + 8'h1;
					stage_q <= 4'h8;
					sri_q <= fbuf[k_q + 8'h1];
					st_q <= (k_q == `RLD_FRM_LAST) ? S_IDLE : S_STS;
				end
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end

	rld_fifo #(
		.W     (16),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (st_q[5]),
		.in_ready  (fifo_ready),
		.in_data   (out_word),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_data)
	);
endmodule
`default_nettype wire

// *** verif/rld_datapath_assertions.sv ***
// Port-level checker for the excitation and synthesis datapath.
// Assumes it is bound into rld_datapath; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module rld_checker (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        enc_valid,
	input wire logic        enc_ready,
	input wire logic        enc_done,
	input wire logic [15:0] enc_block_max,
	input wire logic        sub_valid,
	input wire logic        sub_ready,
	input wire logic [1:0]  sub_index,
	input wire logic        compand_en,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [15:0] out_data
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_DONE_LATENCY: assert property (
		enc_valid && enc_ready |-> ##54 enc_done) else $error("encoder done not at cycle 54");
	AST_ENC_BUSY: assert property (
		enc_valid && enc_ready |=> (!enc_ready && !enc_done) [*8]) else $error("encoder idle too soon");
	AST_DONE_PULSE: assert property (
		enc_done |=> !enc_done) else $error("done longer than one cycle");
	AST_BMAX_HOLD: assert property (
		$changed(enc_block_max) |-> !enc_ready) else $error("block maximum moved while idle");
	AST_SUB_PRIO: assert property (
		enc_valid |-> !sub_ready) else $error("decoder ready beside encoder request");
	AST_SUB_HOLD: assert property (
		sub_valid && sub_ready |=> !sub_ready [*8]) else $error("decoder ready during synthesis");
	AST_SUB_STEP: assert property (
		$changed(sub_index) |-> sub_index == $past(sub_index) + 2'h1) else $error("sub-segment index skipped");
	AST_LOW_BITS: assert property (
		out_valid && !compand_en |-> out_data[2:0] == 3'h0) else $error("low output bits not cleared");
	AST_COMPAND_HIGH: assert property (
		out_valid && compand_en |-> out_data[15:8] == 8'h00) else $error("companded word has upper bits");
	AST_OUT_HOLD: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("output head changed unread");
endmodule

bind rld_datapath rld_checker u_checker (
	.clock(clock), .rst_n(rst_n), .enc_valid(enc_valid), .enc_ready(enc_ready), .enc_done(enc_done),
	.enc_block_max(enc_block_max), .sub_valid(sub_valid), .sub_ready(sub_ready), .sub_index(sub_index),
	.compand_en(compand_en), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
);
`default_nettype wire

// *** verif/rld_partner.sv ***
// Far side: long-term estimate source and consumer of output samples.
// Assumes est_sample is looked up in the same cycle as est_index.
`timescale 1ns/1ns
`default_nettype none
module rld_partner (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [5:0]  est_index,
	output logic      [15:0] est_sample,
	input  wire logic        out_valid,
	output logic             out_ready,
	input  wire logic [15:0] out_data,
	input  wire logic        stall,
	input  wire logic        clear,
	output logic      [15:0] words_q,
	output logic      [2:0]  low_or_q,
	output logic      [7:0]  high_or_q
);
	// A ramp makes every slot of one 40-sample segment distinguishable
	assign est_sample = 16'h0064 + {10'h000, est_index};
	assign out_ready  = !stall;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			words_q   <= 16'h0000;
			low_or_q  <= 3'h0;
			high_or_q <= 8'h00;
		end else if (clear) begin
			words_q   <= 16'h0000;
			low_or_q  <= 3'h0;
			high_or_q <= 8'h00;
		end else if (out_valid && out_ready) begin
			words_q   <= words_q + 16'h0001;
			low_or_q  <= low_or_q | out_data[2:0];
			high_or_q <= high_or_q | out_data[15:8];
		end
	end
endmodule
`default_nettype wire

// *** verif/rpe_ltp_speech_decoder_datapath_bench.sv ***
// Self-checking bench for the excitation and synthesis datapath.
// Assumes rld_datapath and rld_partner compiled first; 20 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module rpe_ltp_speech_decoder_datapath_bench;
	logic         clock, rst_n, enc_valid, enc_ready, enc_done, sub_valid, sub_ready;
	logic         compand_en, law_sel, out_valid, out_ready, stall, clear;
	logic [207:0] enc_pulses;
	logic [47:0]  lar_codes;
	logic [38:0]  enc_coded_pulses, sub_pulses;
	logic [15:0]  enc_block_max, est_sample, hist_data, out_data, words_q;
	logic [7:0]   high_or_q;
	logic [6:0]   hist_age, sub_lag;
	logic [5:0]   enc_coded_max, est_index, sub_coded_max;
	logic [2:0]   low_or_q;
	logic [1:0]   enc_grid, sub_grid, sub_gain, sub_index;
	int           errors, check_count, cycles;
	int           nrf[8] = '{29128, 26215, 23832, 21846, 20165, 18725, 17476, 16384};

	rld_datapath dut (.clock(clock), .rst_n(rst_n), .enc_valid(enc_valid), .enc_ready(enc_ready),
		.enc_pulses(enc_pulses), .enc_grid(enc_grid), .enc_coded_max(enc_coded_max), .est_index(est_index),
		.est_sample(est_sample), .enc_done(enc_done), .enc_block_max(enc_block_max),
		.enc_coded_pulses(enc_coded_pulses), .hist_age(hist_age), .hist_data(hist_data),
		.sub_valid(sub_valid), .sub_ready(sub_ready), .sub_grid(sub_grid), .sub_coded_max(sub_coded_max),
		.sub_pulses(sub_pulses), .sub_lag(sub_lag), .sub_gain(sub_gain), .lar_codes(lar_codes),
		.sub_index(sub_index), .compand_en(compand_en), .law_sel(law_sel), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data));
	rld_partner partner (.clock(clock), .rst_n(rst_n), .est_index(est_index), .est_sample(est_sample),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .stall(stall), .clear(clear),
		.words_q(words_q), .low_or_q(low_or_q), .high_or_q(high_or_q));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Ceiling covers three frames with a stalled drain plus the encoder work
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("unexpected at %0t: cycle limit reached", $time);
			stop_test;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		check_count++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, want);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [2:0] pcode(input logic signed [15:0] x, input logic [5:0] xc);
		int e;
		int m;
		int p;
		logic signed [15:0] t;
		e = (xc > 6'h0f) ? int'(xc >> 3) - 1 : 0;
		m = int'(xc) - e * 8;
		if (m == 0) begin
			e = -4;
			m = 7;
		end else begin
			while (m <= 7) begin
				m = m * 2 + 1;
				e--;
			end
			m = m - 8;
		end
		t = x <<< (6 - e);
		p = (t * nrf[m]) >>> 15;
		return 3'((p >>> 12) + 4);
	endfunction

	task automatic hist_check(input int age, input int want);
		hist_age = 7'(age);
		@(posedge clock);
		#2;
		check(hist_data, 16'(want), "history");
	endtask

	task automatic test_reset;
		check({15'h0000, enc_ready}, 16'h0001, "idle ready");
		check({15'h0000, out_valid}, 16'h0000, "empty fifo");
		check({14'h0000, sub_index}, 16'h0000, "first sub index");
		hist_check(120, 0);
		$display("test reset done");
	endtask

	task automatic enc_case(input logic [1:0] g, input logic [5:0] xc, input int step);
		logic signed [15:0] x;
		logic [15:0] bmax;
		int seen;
		bmax = 16'h0000;
		seen = 0;
		for (int i = 0; i < 13; i++) begin
			x = 16'((i - 7) * step);
			enc_pulses[16*i +: 16] = x;
			if (16'(x < 0 ? -x : x) > bmax)
				bmax = 16'(x < 0 ? -x : x);
		end
		enc_grid = g;
		enc_coded_max = xc;
		enc_valid = 1'b1;
		@(posedge clock);
		while (enc_ready !== 1'b1)
			@(posedge clock);
		#2;
		enc_valid = 1'b0;
		for (int n = 1; n < 60; n++) begin
			@(posedge clock);
			#2;
			if (enc_done === 1'b1 && seen == 0)
				seen = n;
		end
		check(16'(seen), 16'h0035, "done latency");
		check(enc_block_max, bmax, "block maximum");
		for (int i = 0; i < 13; i++)
			check({13'h0000, enc_coded_pulses[3*i +: 3]}, {13'h0000, pcode(enc_pulses[16*i +: 16], xc)},
				"pulse code");
	endtask

	task automatic test_encoder;
		enc_case(2'h1, 6'h28, 600);
		enc_case(2'h2, 6'h05, 13);
		for (int k = 0; k < 40; k++) begin
			if (k % 3 != 2)
				hist_check(40 - k, 100 + k);
			if (k % 3 != 1)
				hist_check(80 - k, 100 + k);
		end
		hist_check(120, 0);
		$display("test encoder done");
	endtask

	task automatic dec_frame(input logic comp, input logic law, input logic hold);
		int n;
		compand_en = comp;
		law_sel = law;
		stall = hold;
		clear = 1'b1;
		@(posedge clock);
		#2;
		clear = 1'b0;
		for (int s = 0; s < 4; s++) begin
			sub_grid = 2'(s);
			sub_gain = 2'(s);
			sub_coded_max = 6'(s * 20);
			sub_lag = (s == 0) ? 7'h1e : (s == 1) ? 7'h28 : (s == 2) ? 7'h78 : 7'h79;
			for (int i = 0; i < 13; i++)
				sub_pulses[3*i +: 3] = 3'(i + s);
			n = 0;
			while (sub_ready !== 1'b1 && n < 3000) begin
				@(posedge clock);
				#2;
				n++;
			end
			check({14'h0000, sub_index}, 16'(s), "sub index");
			sub_valid = 1'b1;
			@(posedge clock);
			#2;
			sub_valid = 1'b0;
		end
		if (hold) begin
			repeat (400) @(posedge clock);
			#2;
			check({15'h0000, out_valid}, 16'h0001, "fifo holds");
			check(words_q, 16'h0000, "nothing popped");
			check({15'h0000, sub_ready}, 16'h0000, "frame still busy");
			stall = 1'b0;
		end
		n = 0;
		while (words_q !== 16'h00a0 && n < 4000) begin
			@(posedge clock);
			#2;
			n++;
		end
		repeat (20) @(posedge clock);
		#2;
		check(words_q, 16'h00a0, "samples per frame");
		check({15'h0000, out_valid}, 16'h0000, "fifo drained");
		if (comp)
			check({8'h00, high_or_q}, 16'h0000, "companded upper byte");
		else
			check({13'h0000, low_or_q}, 16'h0000, "truncated low bits");
		check({14'h0000, sub_index}, 16'h0000, "frame wraps");
		$display("test decoder frame done");
	endtask

	initial begin
		{rst_n, enc_valid, sub_valid, compand_en, law_sel, stall, clear} = 7'h00;
		enc_pulses = 208'h0;
		enc_grid = 2'h0;
		enc_coded_max = 6'h00;
		hist_age = 7'h01;
		sub_grid = 2'h0;
		sub_coded_max = 6'h00;
		sub_pulses = 39'h0;
		sub_lag = 7'h28;
		sub_gain = 2'h0;
		lar_codes = {8{6'h03}};
		repeat (6) @(posedge clock);
		#2;
		rst_n = 1'b1;
		test_reset;
		test_encoder;
		dec_frame(1'b0, 1'b0, 1'b1);
		dec_frame(1'b1, 1'b1, 1'b0);
		dec_frame(1'b1, 1'b0, 1'b0);
		stop_test;
	end
endmodule
`default_nettype wire
